// ---- logic/orf_filter.sv ----
// off-core response filter with register port and counter routing
//
// Contract
// [RL1] bit 0 selects demand data reads
// [RL2] bit 1 selects demand ownership reads
// [RL3] bit 2 selects demand code reads
// [RL4] bit 3 selects writebacks
// [RL5] bits 4-6 select second-level prefetches
// [RL6] bits 7-9 select prefetches toward third level
// [RL7] bit 10 locks, bit 11 streaming stores
// [RL8] bit 15 selects all other requests
// [RL9] bit 16 matches any response
// [RL10] bits 17-22 supplier, 30:23 reserved
// [RL11] bits 31-33 snoop absent, unneeded, missed
// [RL12] bit 34 snoop hit without forward
// [RL13] bit 35 remote socket forwarded data
// [RL14] bit 36 snoop found modified line
// [RL15] bit 37 non-memory target address
// [RL16] software sets a request bit first
// [RL17] no request or response, no count
// [RL18] response valid: any, or supplier and snoop
// [RL19] any bit overrides supplier and snoop
// [RL20] several request and response bits allowed
// [RL21] word layout 15:0, 30:16, 37:31
// [RL22] B7/01 uses cfg0, BB/01 uses cfg1
// [RL23] one pulse per matching transaction
//
// Strobed register access and the placing of the registers were left to the implementer.
module orf_filter #(
   parameter int NUM_CNT = 4               // general counters served
) (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   // register port
   input  wire logic [7:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   // transaction report from the request tracking logic
   input  wire logic                    txn_valid,
   input  orf_pkg::orf_attr_t           txn_attr,
   // results
   output logic      [1:0]              match_pulse,
   output logic      [NUM_CNT-1:0]      cnt_pulse
);

   // configuration words, one per filter
   orf_pkg::orf_attr_t cfg_r [2];
   // event select per counter
   orf_pkg::orf_evsel_t evsel_r [NUM_CNT];
   // registered results
   logic [1:0]          match_r;
   logic [NUM_CNT-1:0]  cnt_r;
   logic [31:0]         rdata_r;
   // combinational helpers
   logic [1:0]          hit_now;
   logic [1:0]          cfg_ok;

   // request side: any selected, defined class of this transaction
   function automatic logic req_hit(input orf_pkg::orf_attr_t c,
                                    input orf_pkg::orf_attr_t t);
      logic [orf_pkg::ORF_REQ_W-1:0] shared_req;   // overlap of both words
      shared_req = c.req & t.req;
      // reserved bits 14:12 are left out, so they never select anything
      req_hit = shared_req[orf_pkg::DEMAND_DATA_READ_SEL]          // [RL1]
              | shared_req[orf_pkg::DEMAND_OWNERSHIP_READ_SEL]     // [RL2]
              | shared_req[orf_pkg::DEMAND_CODE_READ_SEL]          // [RL3]
              | shared_req[orf_pkg::WRITEBACK_SEL]                 // [RL4]
              | shared_req[orf_pkg::L2_PREFETCH_DATA_SEL]          // [RL5]
              | shared_req[orf_pkg::L2_PREFETCH_OWNERSHIP_SEL]     // [RL5]
              | shared_req[orf_pkg::L2_PREFETCH_CODE_SEL]          // [RL5]
              | shared_req[orf_pkg::L3_PREFETCH_LOAD_SEL]          // [RL6]
              | shared_req[orf_pkg::L3_PREFETCH_OWNERSHIP_SEL]     // [RL6]
              | shared_req[orf_pkg::L3_PREFETCH_CODE_SEL]          // [RL6]
              | shared_req[orf_pkg::LOCKED_ACCESS_SEL]             // [RL7]
              | shared_req[orf_pkg::STREAMING_STORE_SEL]           // [RL7]
              | shared_req[orf_pkg::OTHER_REQUEST_SEL];            // [RL8]
   endfunction

   // response side: any, else supplier and snoop both overlap
   function automatic logic resp_hit(input orf_pkg::orf_attr_t c,
                                     input orf_pkg::orf_attr_t t);
      logic sup;
      logic snp;
      logic [orf_pkg::ORF_SNP_W-1:0] shared_snp;   // snoop overlap
      sup = |(c.supp & t.supp & orf_pkg::SUP_DEFINED_MASK); // [RL10]
      shared_snp = c.snoop & t.snoop;
      snp = shared_snp[orf_pkg::SNOOP_INFO_ABSENT]          // [RL11]
          | shared_snp[orf_pkg::SNOOP_UNNEEDED]             // [RL11]
          | shared_snp[orf_pkg::SNOOP_MISSED_ALL]           // [RL11]
          | shared_snp[orf_pkg::SNOOP_HIT_NO_FORWARD]       // [RL12]
          | shared_snp[orf_pkg::SNOOP_REMOTE_FORWARD]       // [RL13]
          | shared_snp[orf_pkg::SNOOP_MODIFIED_HIT]         // [RL14]
          | shared_snp[orf_pkg::TARGET_NON_MEMORY];         // [RL15]
      // the any bit short-circuits the other two fields
      resp_hit = c.supp[orf_pkg::RESP_ANY] | (sup & snp); // [RL9][RL19]
   endfunction

   // a word is usable only with a request bit and a valid response
   function automatic logic cfg_valid(input orf_pkg::orf_attr_t c);
      logic rq;
      logic rs;
      rq = |(c.req & orf_pkg::REQ_DEFINED_MASK); // [RL16][RL17]
      rs = c.supp[orf_pkg::RESP_ANY]
         | (|(c.supp & orf_pkg::SUP_DEFINED_MASK)
            & |(c.snoop & orf_pkg::SNP_DEFINED_MASK)); // [RL18]
      cfg_valid = rq & rs;
   endfunction

   // which filter a counter follows, none when code or mask differ
   function automatic logic [1:0] route(input orf_pkg::orf_evsel_t e);
      logic ok;
      ok = e.en & (e.umask == orf_pkg::EVT_UMASK);
      route = {ok & (e.code == orf_pkg::EVT_CODE_CFG1),
               ok & (e.code == orf_pkg::EVT_CODE_CFG0)}; // [RL22]
   endfunction

   // low word of a configuration, field order fixed by the struct
   function automatic logic [31:0] cfg_lo(input orf_pkg::orf_attr_t c);
      cfg_lo = c[31:0]; // [RL21]
   endfunction

   // high word, bits 37:32 in the low bits, rest read zero
   function automatic logic [31:0] cfg_hi(input orf_pkg::orf_attr_t c);
      cfg_hi = {{(32 - orf_pkg::ORF_HI_W){1'b0}},
                c[orf_pkg::ORF_CFG_W-1:32]};
   endfunction

   // evaluate both filters against the reported transaction
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         cfg_ok[k]  = cfg_valid(cfg_r[k]);
         // several bits may overlap; the OR folds them to one hit
         hit_now[k] = txn_valid & cfg_ok[k]
                    & req_hit(cfg_r[k], txn_attr)
                    & resp_hit(cfg_r[k], txn_attr); // [RL17][RL20]
      end
   end

   // configuration writes; each word split over two bus words
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r[0] <= orf_pkg::CFG_RESET;
         cfg_r[1] <= orf_pkg::CFG_RESET;
      end else if (reg_wr) begin
         unique case (reg_addr)
            orf_pkg::ADDR_CFG0_LO: begin
               cfg_r[0][31:0] <= reg_wdata;
            end
            orf_pkg::ADDR_CFG0_HI: begin
               cfg_r[0][37:32] <= reg_wdata[orf_pkg::ORF_HI_W-1:0];
            end
            orf_pkg::ADDR_CFG1_LO: begin
               cfg_r[1][31:0] <= reg_wdata;
            end
            orf_pkg::ADDR_CFG1_HI: begin
               cfg_r[1][37:32] <= reg_wdata[orf_pkg::ORF_HI_W-1:0];
            end
            default: begin
               // other addresses leave the words alone
            end
         endcase
      end
   end

   // event select writes, one word per counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            evsel_r[i] <= orf_pkg::EVSEL_RESET;
         end
      end else if (reg_wr) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            // word i sits at the base plus four times i
            if (reg_addr == orf_pkg::ADDR_EVSEL0 + 8'(4 * i)) begin
               evsel_r[i] <= reg_wdata[orf_pkg::EVSEL_W-1:0];
            end
         end
      end
   end

   // filter hits, one cycle after the report
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         match_r <= 2'h0;
      end else begin
         match_r <= hit_now; // [RL23]
      end
   end

   // counter pulses: one per transaction however many bits hit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            // a counter follows at most one filter, so no double count
            cnt_r[i] <= |(route(evsel_r[i]) & hit_now); // [RL22][RL23]
         end
      end
   end

   // read data, valid only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_r <= 32'h0000_0000;
         unique case (reg_addr)
            orf_pkg::ADDR_CFG0_LO: rdata_r <= cfg_lo(cfg_r[0]);
            orf_pkg::ADDR_CFG0_HI: rdata_r <= cfg_hi(cfg_r[0]);
            orf_pkg::ADDR_CFG1_LO: rdata_r <= cfg_lo(cfg_r[1]);
            orf_pkg::ADDR_CFG1_HI: rdata_r <= cfg_hi(cfg_r[1]);
            // status: validity per filter and last hit per filter
            orf_pkg::ADDR_STATUS:
               rdata_r <= {28'h000_0000, match_r, cfg_ok};
            default: begin
               for (int i = 0; i < NUM_CNT; i++) begin
                  if (reg_addr == orf_pkg::ADDR_EVSEL0 + 8'(4 * i)) begin
                     rdata_r <= {15'h0000, evsel_r[i]};
                  end
               end
            end
         endcase
      end else begin
         // zero between reads keeps stale data off the bus
         rdata_r <= 32'h0000_0000;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata   = rdata_r;
   assign match_pulse = match_r;
   assign cnt_pulse   = cnt_r;

   // ------------------------------------------------------------------
   // checks beside the logic
   // ------------------------------------------------------------------

   // a counter pulse only follows a reported transaction
   a_pulse_has_txn: assert property ( // [RL23]
      @(posedge core_clk) disable iff (!rst_n)
      |cnt_r |-> $past(txn_valid))
      else $error("counter pulse without a transaction");

   // a filter hit needs a defined request bit set a cycle before
   a_hit_needs_req: assert property ( // [RL17][RL16]
      @(posedge core_clk) disable iff (!rst_n)
      match_r[0] |->
         $past(|(cfg_r[0].req & orf_pkg::REQ_DEFINED_MASK)))
      else $error("filter hit with empty request field");

   // a filter hit needs a valid response pattern
   a_hit_needs_resp: assert property ( // [RL18]
      @(posedge core_clk) disable iff (!rst_n)
      match_r[1] |-> $past(cfg_valid(cfg_r[1])))
      else $error("filter hit with invalid response pattern");

   // any bit plus overlapping request always hits
   a_any_overrides: assert property ( // [RL19][RL9][RL1][RL8][RL20]
      @(posedge core_clk) disable iff (!rst_n)
      (txn_valid && cfg_r[0].supp[orf_pkg::RESP_ANY]
       && |(cfg_r[0].req & txn_attr.req & orf_pkg::REQ_DEFINED_MASK))
      |=> match_r[0])
      else $error("any-response word failed to hit");

   // reserved request bits alone never hit
   a_req_reserved: assert property ( // [RL21][RL7]
      @(posedge core_clk) disable iff (!rst_n)
      (txn_valid && !(|(txn_attr.req & orf_pkg::REQ_DEFINED_MASK)))
      |=> !match_r[0] && !match_r[1])
      else $error("reserved request bits produced a hit");

   // without any, a snoop mismatch blocks a supplier match
   a_snoop_and: assert property ( // [RL11][RL12][RL13][RL14][RL15]
      @(posedge core_clk) disable iff (!rst_n)
      (txn_valid && !cfg_r[0].supp[orf_pkg::RESP_ANY]
       && !(|(cfg_r[0].snoop & txn_attr.snoop)))
      |=> !match_r[0])
      else $error("hit without snoop overlap");

   // reserved supplier bits never stand in for supplier info
   a_supp_reserved: assert property ( // [RL10]
      @(posedge core_clk) disable iff (!rst_n)
      (txn_valid && !cfg_r[1].supp[orf_pkg::RESP_ANY]
       && !(|(txn_attr.supp & orf_pkg::SUP_DEFINED_MASK)))
      |=> !match_r[1])
      else $error("reserved supplier bits produced a hit");

   // counter 0 routed to the second word follows its hits
   a_route_second: assert property ( // [RL22]
      @(posedge core_clk) disable iff (!rst_n)
      (route(evsel_r[0]) == 2'b10 && hit_now[1])
      |=> cnt_r[0] ##1 !cnt_r[0] || $past(hit_now[1]))
      else $error("counter 0 missed a second-filter hit");

   // a disabled counter never pulses
   a_disabled_quiet: assert property ( // [RL22]
      @(posedge core_clk) disable iff (!rst_n)
      !evsel_r[0].en |=> !cnt_r[0])
      else $error("disabled counter pulsed");

   // status read returns validity flags one cycle later
   a_status_read: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == orf_pkg::ADDR_STATUS)
      |=> reg_rdata[1:0] == $past(cfg_ok) && reg_rdata[31:4] == 28'h0)
      else $error("status read data wrong");

   // outside a read the data lines rest at zero
   a_rdata_idle: assert property ( // [RL21]
      @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside a read");

   // the upper half of word 1 reads back in the low six bits
   a_hi_readback: assert property ( // [RL21]
      @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == orf_pkg::ADDR_CFG1_HI)
      |=> reg_rdata == {26'h0, $past(cfg_r[1][37:32])})
      else $error("upper configuration half read back wrong");

   // a low-half write lands whole in word 1
   a_lo_write: assert property ( // [RL21]
      @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == orf_pkg::ADDR_CFG1_LO)
      |=> cfg_r[1][31:0] == $past(reg_wdata))
      else $error("low configuration half not written");

   // an upper-half write keeps only six bits
   a_hi_write: assert property ( // [RL21]
      @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == orf_pkg::ADDR_CFG0_HI)
      |=> cfg_r[0][37:32] == $past(reg_wdata[orf_pkg::ORF_HI_W-1:0]))
      else $error("upper configuration half not written");

   // no report, no hit on either word
   a_no_txn_quiet: assert property ( // [RL23]
      @(posedge core_clk) disable iff (!rst_n)
      !txn_valid |=> match_r == 2'h0)
      else $error("filter hit without a transaction");

   // a word with an empty request field never hits
   a_empty_req_quiet: assert property ( // [RL17]
      @(posedge core_clk) disable iff (!rst_n)
      !(|(cfg_r[1].req & orf_pkg::REQ_DEFINED_MASK)) |=> !match_r[1])
      else $error("hit from a word without request bits");

   // without any, a word with no snoop bit never hits
   a_empty_snoop_quiet: assert property ( // [RL18]
      @(posedge core_clk) disable iff (!rst_n)
      (!cfg_r[1].supp[orf_pkg::RESP_ANY] && cfg_r[1].snoop == '0)
      |=> !match_r[1])
      else $error("hit from a word without snoop bits");

   // without any, a word with no defined supplier bit never hits
   a_empty_supp_quiet: assert property ( // [RL18][RL10]
      @(posedge core_clk) disable iff (!rst_n)
      (!cfg_r[0].supp[orf_pkg::RESP_ANY]
       && !(|(cfg_r[0].supp & orf_pkg::SUP_DEFINED_MASK)))
      |=> !match_r[0])
      else $error("hit from a word without supplier bits");

   // overlap in request, supplier and snoop always hits
   a_full_overlap: assert property ( // [RL18][RL20]
      @(posedge core_clk) disable iff (!rst_n)
      (txn_valid
       && |(cfg_r[1].req & txn_attr.req & orf_pkg::REQ_DEFINED_MASK)
       && |(cfg_r[1].supp & txn_attr.supp & orf_pkg::SUP_DEFINED_MASK)
       && |(cfg_r[1].snoop & txn_attr.snoop))
      |=> match_r[1])
      else $error("fully overlapping transaction missed");

   // a counter on word 0 pulses exactly with word 0's hits
   a_route_first: assert property ( // [RL22][RL23]
      @(posedge core_clk) disable iff (!rst_n)
      (evsel_r[1].en && evsel_r[1].umask == orf_pkg::EVT_UMASK
       && evsel_r[1].code == orf_pkg::EVT_CODE_CFG0)
      |=> cnt_r[1] == match_r[0])
      else $error("counter 1 out of step with word 0");

   // a wrong unit mask keeps a counter silent
   a_umask_quiet: assert property ( // [RL22]
      @(posedge core_clk) disable iff (!rst_n)
      evsel_r[3].umask != orf_pkg::EVT_UMASK |=> !cnt_r[3])
      else $error("counter 3 pulsed with a wrong unit mask");

endmodule

// ---- common/orf_pkg.sv ----
// constants and types for the off-core response event filter
package orf_pkg;
   // configuration word layout
   localparam int ORF_CFG_W   = 38;
   localparam int ORF_REQ_W   = 16;       // request type, bits 15:0
   localparam int ORF_SUP_W   = 15;       // supplier info, bits 30:16
   localparam int ORF_SNP_W   = 7;        // snoop info, bits 37:31
   localparam int ORF_HI_W    = ORF_CFG_W - 32;

   // request bits (position in the request field)
   localparam int DEMAND_DATA_READ_SEL      = 0;
   localparam int DEMAND_OWNERSHIP_READ_SEL = 1;
   localparam int DEMAND_CODE_READ_SEL      = 2;
   localparam int WRITEBACK_SEL             = 3;
   localparam int L2_PREFETCH_DATA_SEL      = 4;
   localparam int L2_PREFETCH_OWNERSHIP_SEL = 5;
   localparam int L2_PREFETCH_CODE_SEL      = 6;
   localparam int L3_PREFETCH_LOAD_SEL      = 7;
   localparam int L3_PREFETCH_OWNERSHIP_SEL = 8;
   localparam int L3_PREFETCH_CODE_SEL      = 9;
   localparam int LOCKED_ACCESS_SEL         = 10;
   localparam int STREAMING_STORE_SEL       = 11;
   localparam int OTHER_REQUEST_SEL         = 15;
   localparam logic [15:0] REQ_DEFINED_MASK = 16'h8FFF;

   // response field bits (position inside the supplier field)
   localparam int RESP_ANY         = 0;   // word bit 16
   localparam int SUPPLIER_UNKNOWN = 1;   // word bit 17
   localparam int L3_HIT_MODIFIED  = 2;
   localparam int L3_HIT_EXCLUSIVE = 3;
   localparam int L3_HIT_SHARED    = 4;
   localparam int L3_HIT_FORWARD   = 5;
   localparam int SUPPLIER_LOCAL   = 6;   // word bit 22
   localparam logic [14:0] SUP_DEFINED_MASK = 15'h007E;

   // snoop field bits (position inside the snoop field)
   localparam int SNOOP_INFO_ABSENT    = 0;   // word bit 31
   localparam int SNOOP_UNNEEDED       = 1;
   localparam int SNOOP_MISSED_ALL     = 2;
   localparam int SNOOP_HIT_NO_FORWARD = 3;
   localparam int SNOOP_REMOTE_FORWARD = 4;
   localparam int SNOOP_MODIFIED_HIT   = 5;
   localparam int TARGET_NON_MEMORY    = 6;   // word bit 37
   localparam logic [6:0] SNP_DEFINED_MASK = 7'h7F;

   // event routing
   localparam logic [7:0] EVT_CODE_CFG0 = 8'hB7;
   localparam logic [7:0] EVT_CODE_CFG1 = 8'hBB;
   localparam logic [7:0] EVT_UMASK     = 8'h01;

   // register map, byte addresses
   localparam int ORF_ADDR_W = 8;
   localparam logic [7:0] ADDR_CFG0_LO = 8'h00;
   localparam logic [7:0] ADDR_CFG0_HI = 8'h04;
   localparam logic [7:0] ADDR_CFG1_LO = 8'h08;
   localparam logic [7:0] ADDR_CFG1_HI = 8'h0C;
   localparam logic [7:0] ADDR_EVSEL0  = 8'h10;   // one word per counter
   localparam logic [7:0] ADDR_STATUS  = 8'h30;
   localparam int EVSEL_EN_BIT = 16;
   localparam int EVSEL_W      = 17;

   // reset values
   localparam logic [37:0] CFG_RESET   = 38'h00_0000_0000;
   localparam logic [16:0] EVSEL_RESET = 17'h0_0000;

   // transaction attributes and configuration share one layout
   typedef struct packed {
      logic [ORF_SNP_W-1:0] snoop;
      logic [ORF_SUP_W-1:0] supp;
      logic [ORF_REQ_W-1:0] req;
   } orf_attr_t;

   // counter event select
   typedef struct packed {
      logic       en;
      logic [7:0] umask;
      logic [7:0] code;
   } orf_evsel_t;
endpackage

// ---- tb/orf_txn_src.sv ----
// partner model: request tracking logic that reports transactions
module orf_txn_src (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // request from the bench
   input  wire logic         go,
   input  orf_pkg::orf_attr_t attr_req,
   // transaction report toward the filter
   output logic              txn_valid,
   output orf_pkg::orf_attr_t txn_attr
);
   timeunit 1ns;
   timeprecision 1ps;
   // one report per cycle; idle attributes flip so stale bits never match
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         txn_valid <= 1'b0;
         txn_attr  <= '0;
      end else begin
         txn_valid <= go;
         txn_attr  <= go ? attr_req : ~txn_attr;
      end
   end
endmodule

// ---- tb/tb_orf_filter.sv ----
// self-checking bench for the off-core response filter
module tb_orf_filter;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset and register port
   logic               core_clk  = 1'b0;
   logic               rst_n     = 1'b0;
   logic [7:0]         reg_addr  = 8'h00;
   logic [31:0]        reg_wdata = 32'h0;
   logic               reg_wr    = 1'b0;
   logic               reg_rd    = 1'b0;
   logic [31:0]        reg_rdata;
   // transaction side
   logic               go        = 1'b0;
   orf_pkg::orf_attr_t attr_req  = '0;
   logic               txn_valid;
   orf_pkg::orf_attr_t txn_attr;
   logic [1:0]         match_pulse;
   logic [3:0]         cnt_pulse;
   // shadow copies of what software wrote
   logic [37:0]        cfg_s [2] = '{default: '0};
   logic [16:0]        ev_s  [4] = '{default: '0};
   logic [7:0]         addrs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                      8'h14, 8'h18, 8'h1C, 8'h30, 8'h40};
   int                 mismatches  = 0;
   int                 comparisons = 0;

   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;

   orf_txn_src src_u (.core_clk(core_clk), .rst_n(rst_n), .go(go),
      .attr_req(attr_req), .txn_valid(txn_valid), .txn_attr(txn_attr));

   orf_filter #(.NUM_CNT(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn_valid(txn_valid),
      .txn_attr(txn_attr), .match_pulse(match_pulse),
      .cnt_pulse(cnt_pulse));

   // response part: any wins, else a supplier and a snoop bit must meet
   function automatic logic resp_ok(logic [37:0] c, logic [37:0] t);
      return c[16] | (|(c[22:17] & t[22:17]) & |(c[37:31] & t[37:31]));
   endfunction

   // a hit needs a shared defined request bit and a good response
   function automatic logic hit(logic [37:0] c, logic [37:0] t);
      return |(c[15:0] & t[15:0] & 16'h8FFF) & resp_ok(c, t);
   endfunction

   // counter routing from the event selects
   function automatic logic [3:0] exp_cnt(logic [1:0] m);
      for (int i = 0; i < 4; i++)
         exp_cnt[i] = ev_s[i][16] && ev_s[i][15:8] == 8'h01 &&
            (ev_s[i][7:0] == 8'hB7 ? m[0] : ev_s[i][7:0] == 8'hBB && m[1]);
   endfunction

   // read value expected at an address; unmapped reads give zero
   function automatic logic [31:0] rd_exp(logic [7:0] a);
      case (a)
         8'h00, 8'h08: return cfg_s[a[3]][31:0];
         8'h04, 8'h0C: return {26'h0, cfg_s[a[3]][37:32]};
         8'h10, 8'h14, 8'h18, 8'h1C: return {15'h0, ev_s[a[3:2]]};
         8'h30: return {30'h0, hit(cfg_s[1], '1), hit(cfg_s[0], '1)};
         default: return 32'h0;
      endcase
   endfunction

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one write cycle; the shadow follows at the taking edge
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      if (a == 8'h00 || a == 8'h08) cfg_s[a[3]][31:0] <= d;
      if (a == 8'h04 || a == 8'h0C) cfg_s[a[3]][37:32] <= d[5:0];
      if (a[7:4] == 4'h1 && a[1:0] == 2'b00) ev_s[a[3:2]] <= d[16:0];
   endtask

   // one read cycle; data looked at only in the following cycle
   task automatic rd(logic [7:0] a);
      logic [31:0] e;
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      e = rd_exp(a);
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask

   task automatic cfg(int k, logic [37:0] c);
      wr(8'(8 * k), c[31:0]);
      wr(8'(8 * k + 4), {26'h0, c[37:32]});
   endtask

   // holds go high; consecutive calls give back-to-back reports
   task automatic send(logic [37:0] a);
      @(posedge core_clk);
      go      <= 1'b1;
      attr_req <= a;
   endtask

   task automatic idle(int n);
      @(posedge core_clk);
      go <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // pulse checker: expectation uses the configuration before the edge
   always @(posedge core_clk) begin
      logic [1:0] em;
      logic [3:0] ec;
      logic       live;
      live  = rst_n;
      em[0] = txn_valid && hit(cfg_s[0], txn_attr);
      em[1] = txn_valid && hit(cfg_s[1], txn_attr);
      ec    = exp_cnt(em);
      #1;
      if (live) begin
         chk("match_pulse", 32'(em), 32'(match_pulse));
         chk("cnt_pulse", 32'(ec), 32'(cnt_pulse));
      end
   end

   // hang guard
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end

   initial begin
      logic [37:0] c;
      void'($urandom(15));
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values, an unmapped place, the narrow upper half
      foreach (addrs[i]) rd(addrs[i]);
      wr(8'h40, 32'hFFFFFFFF);
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h40);
      rd(8'h04);
      // counters: two routed, one disabled, one with a wrong mask
      wr(8'h10, 32'h0001_01B7);
      wr(8'h14, 32'h0001_01BB);
      wr(8'h18, 32'h0000_01B7);
      wr(8'h1C, 32'h0001_02B7);
      // each request bit alone with the catch-all response
      for (int b = 0; b < 16; b++) begin
         cfg(0, 38'h1_0000 | (38'h1 << b));
         cfg(1, 38'(16'(1 << b)));
         send(38'(16'(1 << b)));
         send({22'h3F_FFFF, ~16'(1 << b)});
         idle(2);
      end
      // each supplier and snoop bit against a full opposite field
      for (int s = 17; s < 38; s++) begin
         c = (38'h1 << s) | 38'hFFFF;
         c |= s < 31 ? 38'h3F_8000_0000 : 38'h00_007E_0000;
         cfg(0, c);
         cfg(1, {7'h0, c[30:0]});
         send(c);
         send(c & ~(38'h1 << s));
         idle(2);
         rd(8'h30);
      end
      // random words, routing and back-to-back traffic
      repeat (8) begin
         for (int k = 0; k < 2; k++)
            cfg(k, 38'({$urandom, $urandom}));
         for (int i = 0; i < 4; i++)
            wr(8'h10 + 8'(4 * i), {15'h0, 1'($urandom),
               ($urandom % 3) ? 8'h01 : 8'h02,
               ($urandom % 2) ? 8'hB7 : 8'hBB});
         repeat (40) begin
            if ($urandom % 4)
               send(38'({$urandom, $urandom}));
            else
               idle(0);
         end
         idle(3);
         foreach (addrs[i]) rd(addrs[i]);
      end
      wrap_up();
   end
endmodule
